// file: core/gauge_cfg_pkg.sv
// constants for the pack configuration register bank
package gauge_cfg_pkg;
  // ---------------------------------------------------------------
  // register map (word index on the plain register port)
  // ---------------------------------------------------------------
  localparam int          ADDR_W           = 4;
  localparam logic [3:0]  ADDR_PRIMARY     = 4'h0;
  localparam logic [3:0]  ADDR_SECONDARY   = 4'h1;
  localparam logic [3:0]  ADDR_SOC_DISPLAY = 4'h2;
  localparam logic [3:0]  ADDR_STATUS      = 4'h3;
  localparam logic [3:0]  ADDR_CAL_PARAM   = 4'h4;
  localparam logic [3:0]  ADDR_OFFSET      = 4'h5;
  // ---------------------------------------------------------------
  // primary word fields
  // ---------------------------------------------------------------
  localparam int BIT_RESERVE_COMP   = 15;
  localparam int BIT_CAL_PERMIT     = 14;
  localparam int BIT_RESCALE_NOTICE = 13;
  localparam int BIT_DIVIDER_SEL    = 11;
  localparam int BIT_WAKE_EN        = 10;
  localparam int BIT_WAKE_HI        = 9;
  localparam int BIT_WAKE_LO        = 8;
  localparam int BIT_RES_STEP       = 7;
  localparam int BIT_LOW_POWER      = 6;
  localparam int BIT_FULL_COPY      = 5;
  localparam int BIT_TEMP_SLOPE     = 4;
  localparam int BIT_NEG_VOLT       = 3;
  localparam int BIT_PASSED_CLR     = 2;
  localparam int BIT_GND_SEL        = 1;
  localparam int BIT_TEMP_SRC       = 0;
  localparam logic [15:0] PRIMARY_MASK  = 16'hEFFF;
  localparam logic [15:0] PRIMARY_RESET = 16'h01E1;
  // ---------------------------------------------------------------
  // secondary and display words
  // ---------------------------------------------------------------
  localparam logic [7:0]  SECONDARY_MASK  = 8'hAF;
  localparam logic [7:0]  SECONDARY_RESET = 8'hA3;
  localparam logic [7:0]  SOC_RESET       = 8'h00;
  localparam int BIT_TEMP_BANDED  = 3;
  localparam int BIT_HOLD         = 6;
  localparam int BIT_ZERO_LOCK    = 3;
  localparam int BIT_RELAX_JUMP   = 2;
  localparam int BIT_RELAX_SMOOTH = 1;
  localparam int BIT_SMOOTH       = 0;
  // ---------------------------------------------------------------
  // autocalibration timing and defaults
  // ---------------------------------------------------------------
  localparam int  CLK_MHZ          = 125;
  localparam int  BUS_LOW_US       = 1000;
  localparam int  BUS_LOW_CYCLES   = BUS_LOW_US * CLK_MHZ;
  localparam int  CAL_CYCLES       = 64;
  localparam int  CNT_W            = 24;
  localparam logic [15:0] CAL_PARAM_RESET = 16'h0010;
endpackage : gauge_cfg_pkg

// file: core/gauge_pack_config_autocal.sv
// pack configuration register bank with current-sense offset autocalibration
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
module gauge_pack_config_autocal #(
  parameter int SW         = 16,
  parameter int BUS_LOW_CY = gauge_cfg_pkg::BUS_LOW_CYCLES
) (
  input  wire logic                             clk,
  input  wire logic                             sys_rst,
  input  wire logic [gauge_cfg_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]                      reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [15:0]                      reg_rdata,
  input  wire logic                             bus_lines_low,
  input  wire logic signed [SW-1:0]             sense_voltage,
  input  wire logic                             sample_valid,
  input  wire logic [15:0]                      deadband,
  input  wire logic                             avg_current_low,
  input  wire logic                             voltage_delta_hit,
  input  wire logic                             temp_delta_hit,
  input  wire logic                             voltage_drop_abort,
  input  wire logic                             nickel_chem,
  input  wire logic                             relax_exit,
  input  wire logic                             depth_updated,
  input  wire logic                             charge_term,
  input  wire logic                             cal_mode_req,
  input  wire logic                             sleep_ok,
  input  wire logic                             discharging,
  input  wire logic                             relaxing,
  input  wire logic                             at_zero,
  output logic signed [SW-1:0]                  sense_corrected,
  output logic                                  cal_busy,
  output logic                                  cal_mode_enter,
  output logic                                  sleep_enter,
  output logic                                  load_rm_from_fcc,
  output logic                                  clear_passed_charge,
  output logic                                  term_temp_slope,
  output logic                                  term_neg_voltage,
  output logic                                  divider_select,
  output logic [2:0]                            wake_config,
  output logic                                  reserve_noload_comp,
  output logic                                  resistance_step_enable,
  output logic                                  adc_ground_select,
  output logic                                  temp_source_select,
  output logic                                  temp_banded_charging,
  output logic                                  charge_percent_hold,
  output logic                                  zero_lock_active,
  output logic                                  relax_jump_permit,
  output logic                                  relax_smoothing_permit
);
  import gauge_cfg_pkg::*;

  default clocking chk_clk @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN} cal_state_t;

  logic [15:0]            primary_q;
  logic [7:0]             secondary_q;
  logic [7:0]             soc_q;
  cal_state_t             cal_q;
  logic [CNT_W-1:0]       low_cnt_q;
  logic [7:0]             run_cnt_q;
  logic signed [SW-1:0]   offset_q;
  logic signed [SW-1:0]   last_q;
  logic                   bus_cal_done_q;
  logic                   aborted_q;
  logic [15:0]            cal_count_q;
  logic                   start_bus;
  logic                   start_cond;

  function automatic logic [15:0] abs16(input logic signed [SW-1:0] v);
    logic signed [SW-1:0] a;
    a = (v < 0) ? -v : v;
    return 16'(a);
  endfunction : abs16

  // ---------------------------------------------------------------
  // configuration words
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      primary_q   <= PRIMARY_RESET;
      secondary_q <= SECONDARY_RESET;
      soc_q       <= SOC_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_PRIMARY:     primary_q   <= reg_wdata & PRIMARY_MASK;
        ADDR_SECONDARY:   secondary_q <= reg_wdata[7:0] & SECONDARY_MASK;
        ADDR_SOC_DISPLAY: soc_q       <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read port; data stand in the cycle after the strobe only
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_PRIMARY:     reg_rdata <= primary_q;
        ADDR_SECONDARY:   reg_rdata <= {8'h00, secondary_q};
        ADDR_SOC_DISPLAY: reg_rdata <= {8'h00, soc_q};
        ADDR_STATUS:      reg_rdata <= {13'h0000, aborted_q, bus_cal_done_q, cal_busy};
        ADDR_CAL_PARAM:   reg_rdata <= cal_count_q;
        ADDR_OFFSET:      reg_rdata <= 16'(offset_q);
        default:          reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // autocalibration trigger and sequence
  // ---------------------------------------------------------------
  assign start_bus  = (low_cnt_q >= CNT_W'(BUS_LOW_CY)) && !bus_cal_done_q &&
                      (abs16(sense_voltage) > deadband);
  assign start_cond = avg_current_low && (voltage_delta_hit || temp_delta_hit);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt_q <= '0;
    end else if (!bus_lines_low) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != '1) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_q          <= CAL_IDLE;
      run_cnt_q      <= 8'h00;
      offset_q       <= '0;
      bus_cal_done_q <= 1'b0;
      aborted_q      <= 1'b0;
      cal_busy       <= 1'b0;
    end else begin
      if (!bus_lines_low) begin
        bus_cal_done_q <= 1'b0;
      end
      unique case (cal_q)
        CAL_IDLE: begin
          if (start_bus || start_cond) begin
            cal_q     <= CAL_RUN;
            run_cnt_q <= 8'h00;
            cal_busy  <= 1'b1;
            aborted_q <= 1'b0;
            if (start_bus) begin
              bus_cal_done_q <= 1'b1; // one bus-low calibration per low period
            end
          end
        end
        CAL_RUN: begin
          if (voltage_drop_abort) begin
            cal_q     <= CAL_IDLE;
            cal_busy  <= 1'b0;
            aborted_q <= 1'b1;
          end else if (run_cnt_q == 8'(CAL_CYCLES - 1)) begin
            cal_q    <= CAL_IDLE;
            cal_busy <= 1'b0;
            offset_q <= sense_voltage; // settled zero-input reading
          end else begin
            run_cnt_q <= run_cnt_q + 8'h01;
          end
        end
        default: begin
          cal_q    <= CAL_IDLE;
          cal_busy <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_count_q <= CAL_PARAM_RESET;
    end else if (cal_q == CAL_RUN && cal_busy && run_cnt_q == 8'(CAL_CYCLES - 1) && !voltage_drop_abort) begin
      cal_count_q <= cal_count_q + 16'h0001;
    end
  end

  // sample path holds the last rate while calibrating
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_q          <= '0;
      sense_corrected <= '0;
    end else if (sample_valid && !cal_busy) begin
      last_q          <= sense_voltage - offset_q;
      sense_corrected <= sense_voltage - offset_q;
    end else begin
      sense_corrected <= last_q;
    end
  end

  // ---------------------------------------------------------------
  // configuration decode to gauge controls
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_mode_enter         <= 1'b0;
      sleep_enter            <= 1'b0;
      load_rm_from_fcc       <= 1'b0;
      clear_passed_charge    <= 1'b0;
      term_temp_slope        <= 1'b0;
      term_neg_voltage       <= 1'b0;
      divider_select         <= 1'b0;
      wake_config            <= 3'h1;
      reserve_noload_comp    <= 1'b0;
      resistance_step_enable <= 1'b1;
      adc_ground_select      <= 1'b0;
      temp_source_select     <= 1'b1;
      temp_banded_charging   <= 1'b0;
      charge_percent_hold    <= 1'b0;
      zero_lock_active       <= 1'b0;
      relax_jump_permit      <= 1'b0;
      relax_smoothing_permit <= 1'b0;
    end else begin
      cal_mode_enter         <= cal_mode_req && primary_q[BIT_CAL_PERMIT];
      sleep_enter            <= sleep_ok && primary_q[BIT_LOW_POWER];
      load_rm_from_fcc       <= charge_term && primary_q[BIT_FULL_COPY];
      clear_passed_charge    <= relax_exit && depth_updated && primary_q[BIT_PASSED_CLR];
      term_temp_slope        <= nickel_chem && primary_q[BIT_TEMP_SLOPE];
      term_neg_voltage       <= nickel_chem && primary_q[BIT_NEG_VOLT];
      divider_select         <= primary_q[BIT_DIVIDER_SEL];
      wake_config            <= primary_q[BIT_WAKE_EN:BIT_WAKE_LO];
      reserve_noload_comp    <= primary_q[BIT_RESERVE_COMP];
      resistance_step_enable <= primary_q[BIT_RES_STEP];
      adc_ground_select      <= primary_q[BIT_GND_SEL];
      temp_source_select     <= primary_q[BIT_TEMP_SRC];
      temp_banded_charging   <= secondary_q[BIT_TEMP_BANDED];
      charge_percent_hold    <= discharging && soc_q[BIT_HOLD];
      zero_lock_active       <= relaxing && at_zero && soc_q[BIT_ZERO_LOCK];
      relax_jump_permit      <= soc_q[BIT_SMOOTH] && soc_q[BIT_RELAX_JUMP];
      relax_smoothing_permit <= soc_q[BIT_SMOOTH] && soc_q[BIT_RELAX_SMOOTH];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_sleep_gated: assert property (@(posedge clk) disable iff (sys_rst)
    sleep_enter |-> $past(primary_q[BIT_LOW_POWER])) else $error("sleep entered without permit");
  chk_cal_permit: assert property (@(posedge clk) disable iff (sys_rst)
    cal_mode_enter |-> $past(primary_q[BIT_CAL_PERMIT] && cal_mode_req)) else $error("cal mode without permit");
  chk_nickel_only: assert property (@(posedge clk) disable iff (sys_rst)
    (term_temp_slope || term_neg_voltage) |-> $past(nickel_chem)) else $error("termination without nickel");
  chk_primary_rsvd: assert property (@(posedge clk) disable iff (sys_rst)
    primary_q[12] == 1'b0 && secondary_q[6] == 1'b0 && secondary_q[4] == 1'b0) else $error("reserved bit set");
  chk_abort_stops: assert property (@(posedge clk) disable iff (sys_rst)
    (cal_busy && voltage_drop_abort) |=> !cal_busy && aborted_q) else $error("abort ignored");
  chk_hold_rate: assert property (@(posedge clk) disable iff (sys_rst)
    cal_busy |=> sense_corrected == $past(last_q)) else $error("rate not held");
  chk_full_copy: assert property (@(posedge clk) disable iff (sys_rst)
    (charge_term && primary_q[BIT_FULL_COPY]) |=> load_rm_from_fcc) else $error("full copy missed");
  chk_smooth_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (relax_jump_permit || relax_smoothing_permit) |-> $past(soc_q[BIT_SMOOTH])) else $error("relax without smoothing");
  chk_passed_clr: assert property (@(posedge clk) disable iff (sys_rst)
    clear_passed_charge |-> $past(relax_exit && depth_updated)) else $error("bad passed charge clear");

  chk_divider_follow: assert property (
    divider_select == $past(primary_q[BIT_DIVIDER_SEL]))
    else $error("divider not following");

  chk_wake_follow: assert property (
    wake_config == $past(primary_q[BIT_WAKE_EN:BIT_WAKE_LO]))
    else $error("wake config not following");

  chk_reserve_follow: assert property (
    reserve_noload_comp == $past(primary_q[BIT_RESERVE_COMP]))
    else $error("reserve comp not following");

  chk_step_follow: assert property (
    resistance_step_enable == $past(primary_q[BIT_RES_STEP]))
    else $error("step enable not following");

  chk_gnd_follow: assert property (
    adc_ground_select == $past(primary_q[BIT_GND_SEL]))
    else $error("ground select not following");

  chk_temp_src: assert property (
    temp_source_select == $past(primary_q[BIT_TEMP_SRC]))
    else $error("temp source not following");

  chk_banded_follow: assert property (
    temp_banded_charging == $past(secondary_q[BIT_TEMP_BANDED]))
    else $error("banded charging not following");

  chk_hold_gate: assert property (
    charge_percent_hold |-> $past(discharging && soc_q[BIT_HOLD]))
    else $error("hold outside discharge");

  chk_zero_lock: assert property (
    zero_lock_active |-> $past(relaxing && at_zero))
    else $error("zero lock outside relax");

  chk_sleep_block: assert property (
    !primary_q[BIT_LOW_POWER] |=> !sleep_enter)
    else $error("sleep not blocked");

  chk_permit_block: assert property (
    !primary_q[BIT_CAL_PERMIT] |=> !cal_mode_enter)
    else $error("cal mode not blocked");

  chk_fcc_block: assert property (
    !primary_q[BIT_FULL_COPY] |=> !load_rm_from_fcc)
    else $error("full copy not blocked");

  chk_bus_start: assert property (
    (start_bus && !cal_busy) |=> cal_busy)
    else $error("bus-low calibration missed");

  chk_once_per_low: assert property (
    (bus_cal_done_q && bus_lines_low) |=> bus_cal_done_q)
    else $error("second calibration in low period");

  chk_run_bound: assert property (
    cal_busy |-> run_cnt_q < 8'(CAL_CYCLES))
    else $error("calibration overran");

  chk_cond_start: assert property (
    (!cal_busy && avg_current_low && (voltage_delta_hit || temp_delta_hit)) |=> cal_busy)
    else $error("condition calibration missed");

  chk_offset_sub: assert property (
    (sample_valid && !cal_busy) |=> sense_corrected == $past(sense_voltage - offset_q))
    else $error("offset not subtracted");

  chk_offset_latch: assert property (
    ($fell(cal_busy) && !aborted_q) |-> offset_q == $past(sense_voltage))
    else $error("offset not latched");

  chk_offset_kept: assert property (
    !$past(cal_busy) |-> $stable(offset_q))
    else $error("offset changed while idle");

  chk_rescale_store: assert property (
    $past(reg_wr && reg_addr == ADDR_PRIMARY) |->
      primary_q[BIT_RESCALE_NOTICE] == $past(reg_wdata[BIT_RESCALE_NOTICE]))
    else $error("rescale bit not stored");

  chk_rsvd_read: assert property (
    $past(reg_rd && reg_addr == ADDR_PRIMARY) |-> reg_rdata[12] == 1'b0)
    else $error("reserved bit read back");

  chk_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside slot");

endmodule : gauge_pack_config_autocal

// file: testbench/gauge_pack_config_autocal_tb.sv
// self-checking bench for the pack configuration register bank
`timescale 1ns/10ps
module gauge_pack_config_autocal_tb;
  import gauge_cfg_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic               clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic               bus_lines_low = 1'b0, sample_valid = 1'b0, avg_current_low = 1'b0;
  logic               voltage_delta_hit = 1'b0, temp_delta_hit = 1'b0, voltage_drop_abort = 1'b0;
  logic               nickel_chem = 1'b0, relax_exit = 1'b0, depth_updated = 1'b0, charge_term = 1'b0;
  logic               cal_mode_req = 1'b0, sleep_ok = 1'b0, discharging = 1'b0, relaxing = 1'b0, at_zero = 1'b0;
  logic [3:0]         reg_addr = 4'h0;
  logic [15:0]        reg_wdata = 16'h0000, deadband = 16'h0010, reg_rdata, rnd, p;
  logic signed [15:0] sense_voltage = 16'sh0000, sense_corrected;
  logic [2:0]         wake_config;
  logic               cal_busy, cal_mode_enter, sleep_enter, load_rm_from_fcc, clear_passed_charge;
  logic               term_temp_slope, term_neg_voltage, divider_select, reserve_noload_comp;
  logic               resistance_step_enable, adc_ground_select, temp_source_select, temp_banded_charging;
  logic               charge_percent_hold, zero_lock_active, relax_jump_permit, relax_smoothing_permit;
  logic               rd_seen = 1'b0;
  logic [15:0]        exp_q[$];
  int                 err_count = 0, num_checks = 0, n;
  logic [7:0]         disp_tbl[5] = '{8'h04, 8'h05, 8'h02, 8'h03, 8'h48};

  gauge_pack_config_autocal #(.SW(16), .BUS_LOW_CY(20)) uut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_lines_low(bus_lines_low), .sense_voltage(sense_voltage),
    .sample_valid(sample_valid), .deadband(deadband), .avg_current_low(avg_current_low),
    .voltage_delta_hit(voltage_delta_hit), .temp_delta_hit(temp_delta_hit),
    .voltage_drop_abort(voltage_drop_abort), .nickel_chem(nickel_chem), .relax_exit(relax_exit),
    .depth_updated(depth_updated), .charge_term(charge_term), .cal_mode_req(cal_mode_req),
    .sleep_ok(sleep_ok), .discharging(discharging), .relaxing(relaxing), .at_zero(at_zero),
    .sense_corrected(sense_corrected), .cal_busy(cal_busy), .cal_mode_enter(cal_mode_enter),
    .sleep_enter(sleep_enter), .load_rm_from_fcc(load_rm_from_fcc), .clear_passed_charge(clear_passed_charge),
    .term_temp_slope(term_temp_slope), .term_neg_voltage(term_neg_voltage), .divider_select(divider_select),
    .wake_config(wake_config), .reserve_noload_comp(reserve_noload_comp),
    .resistance_step_enable(resistance_step_enable), .adc_ground_select(adc_ground_select),
    .temp_source_select(temp_source_select), .temp_banded_charging(temp_banded_charging),
    .charge_percent_hold(charge_percent_hold), .zero_lock_active(zero_lock_active),
    .relax_jump_permit(relax_jump_permit), .relax_smoothing_permit(relax_smoothing_permit)
  );

  initial begin
    forever #4 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] expd);
    num_checks++;
    if (seen !== expd) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, expd, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  // strobes stay up between calls so back-to-back cycles never drive twice per step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_rd    <= 1'b0;
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
  endtask : rd

  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : idle

  task automatic wait_busy(input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (cal_busy !== lvl && cnt < 300);
    if (cnt >= 300) begin
      err_count++;
      $display("unexpected cal_busy wait: expected %b seen %b", lvl, cal_busy);
      stop_test();
    end else begin
      @(posedge clk);
    end
  endtask : wait_busy

  // read data belong to the cycle after the strobe only
  always @(posedge clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) check("read queue", 16'h0000, 16'hFFFF);
      else check("reg_rdata", reg_rdata, exp_q.pop_front());
    end
    rd_seen <= reg_rd;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hC7C98E93));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_PRIMARY, 16'h01E1);
    rd(ADDR_SECONDARY, 16'h00A3);
    rd(ADDR_SOC_DISPLAY, 16'h0000);
    rd(ADDR_CAL_PARAM, CAL_PARAM_RESET);
    idle();
    @(negedge clk);
    check("wake_config", 16'(wake_config), 16'h0001);
    check("res_step", 16'(resistance_step_enable), 16'h0001);
    check("temp_source", 16'(temp_source_select), 16'h0001);
    check("divider", 16'(divider_select), 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      rnd = 16'($urandom);
      wr(ADDR_PRIMARY, rnd);
      idle();
      @(negedge clk);
      check("divider", 16'(divider_select), 16'(rnd[BIT_DIVIDER_SEL]));
      check("wake_config", 16'(wake_config), 16'(rnd[10:8]));
      check("reserve_comp", 16'(reserve_noload_comp), 16'(rnd[BIT_RESERVE_COMP]));
      check("res_step", 16'(resistance_step_enable), 16'(rnd[BIT_RES_STEP]));
      check("gnd_sel", 16'(adc_ground_select), 16'(rnd[BIT_GND_SEL]));
      check("temp_source", 16'(temp_source_select), 16'(rnd[BIT_TEMP_SRC]));
      @(posedge clk);
      rd(ADDR_PRIMARY, rnd & 16'hEFFF);
      idle();
    end
    wr(ADDR_SECONDARY, 16'hFFFF);
    rd(ADDR_SECONDARY, 16'h00AF);
    wr(4'hF, 16'hFFFF);
    wr(ADDR_CAL_PARAM, 16'hFFFF);
    rd(4'hF, 16'h0000);
    rd(ADDR_CAL_PARAM, CAL_PARAM_RESET);
    idle();
    @(negedge clk);
    check("banded", 16'(temp_banded_charging), 16'h0001);
    $display("test register access done");
    discharging <= 1'b1;
    relaxing    <= 1'b1;
    at_zero     <= 1'b1;
    foreach (disp_tbl[i]) begin
      @(posedge clk);
      wr(ADDR_SOC_DISPLAY, {8'h00, disp_tbl[i]});
      idle();
      @(negedge clk);
      check("hold", 16'(charge_percent_hold), 16'(disp_tbl[i][6]));
      check("zero_lock", 16'(zero_lock_active), 16'(disp_tbl[i][3]));
      check("jump", 16'(relax_jump_permit), 16'(disp_tbl[i][2] & disp_tbl[i][0]));
      check("smooth", 16'(relax_smoothing_permit), 16'(disp_tbl[i][1] & disp_tbl[i][0]));
    end
    $display("test display word done");
    for (int i = 0; i < 4; i++) begin
      p = i[0] ? 16'h407C : 16'h0000;
      @(posedge clk);
      wr(ADDR_PRIMARY, p);
      reg_wr        <= 1'b0;
      nickel_chem   <= i[1];
      {cal_mode_req, sleep_ok, charge_term, relax_exit, depth_updated} <= 5'h1F;
      @(posedge clk);
      @(negedge clk);
      check("cal_enter", 16'(cal_mode_enter), 16'(p[BIT_CAL_PERMIT]));
      check("sleep", 16'(sleep_enter), 16'(p[BIT_LOW_POWER]));
      check("fcc_copy", 16'(load_rm_from_fcc), 16'(p[BIT_FULL_COPY]));
      check("slope_term", 16'(term_temp_slope), 16'(p[BIT_TEMP_SLOPE] & i[1]));
      check("neg_term", 16'(term_neg_voltage), 16'(p[BIT_NEG_VOLT] & i[1]));
      check("qp_clear", 16'(clear_passed_charge), 16'(p[BIT_PASSED_CLR]));
      @(posedge clk);
      {cal_mode_req, sleep_ok, charge_term, relax_exit, depth_updated} <= 5'h00;
    end
    $display("test gated requests done");
    // the offset is taken from the raw sense value at the end of the window
    sense_voltage <= 16'sh0040;
    bus_lines_low <= 1'b1;
    wait_busy(1'b1, n);
    wait_busy(1'b0, n);
    check("cal_length", 16'(n), 16'(CAL_CYCLES));
    bus_lines_low <= 1'b0;
    rd(ADDR_OFFSET, 16'h0040);
    idle();
    sense_voltage <= 16'sh0050;
    sample_valid  <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    @(negedge clk);
    check("corrected", sense_corrected, 16'h0010);
    $display("test bus-low calibration done");
    @(posedge clk);
    sense_voltage     <= 16'sh0070;
    avg_current_low   <= 1'b1;
    voltage_delta_hit <= 1'b1;
    wait_busy(1'b1, n);
    avg_current_low   <= 1'b0;
    voltage_delta_hit <= 1'b0;
    sample_valid      <= 1'b1;
    @(posedge clk);
    sample_valid       <= 1'b0;
    voltage_drop_abort <= 1'b1;
    @(negedge clk);
    check("corrected_hold", sense_corrected, 16'h0010);
    wait_busy(1'b0, n);
    check("abort_fast", 16'(n <= 3), 16'h0001);
    voltage_drop_abort <= 1'b0;
    rd(ADDR_OFFSET, 16'h0040);
    rd(ADDR_STATUS, 16'h0004);
    rd(ADDR_CAL_PARAM, CAL_PARAM_RESET + 16'h0001);
    idle();
    @(negedge clk);
    check("corrected_after", sense_corrected, 16'h0010);
    $display("test abort done");
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule : gauge_pack_config_autocal_tb
